// File: core/uart_flags_dev.sv
// Status flag logic of the asynchronous serial interface (device end).
`timescale 1ns/10ps
`include "uart_flags_defines.svh"

// Overview of operation
// - Tx-empty sets when shifter takes byte.
// - Tx-empty clears: armed status read, low write.
// - Tx-done held low while sending.
// - Tx-done sets when empty and line idle.
// - Tx-done clears by sequence or queuing.
// - Simultaneous set and clear leaves tx-done clear.
// - Rx-full sets on transfer, clears by sequence.
// - Idle sets after 10 or 11 ones.
// - Idle re-arms only after a new frame.
// - Wakeup mode suppresses idle flag.
// - Idle clears by status then low read.
// - Overrun sets when second frame completes unread.
// - Overrun discards new frame, keeps old data.
// - Overrun clears by status then low read.
// - Host adds dummy low read for stale overrun.
// - Noise flag sets with rx-full, not overrun.
// - Framing error sets on zero stop bit.
// - Framing error blocks reception until cleared.
// - Parity error sets on mismatch when enabled.
// - Status read must precede the data access.
// - Status register writes ignored, reads anytime.
// - Interrupts gated by their enable bits.
module uart_flags_dev (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port
  uart_flags_if.dev       bus,
  // Transmitter events
  input  wire logic       tx_shift_load,
  input  wire logic       tx_active,
  input  wire logic       tx_queue,
  output logic [8:0]      tx_data,
  output logic            tx_line_idle,
  // Receiver events
  input  wire logic       rx_done,
  input  wire logic [8:0] rx_data,
  input  wire logic       rx_noise,
  input  wire logic       rx_stop_bit,
  input  wire logic       rx_parity_bit,
  input  wire logic       bit_tick,
  input  wire logic       rxd_level,
  output logic            rx_inhibit,
  // Configuration
  input  wire logic       nine_bit,
  input  wire logic       parity_enable,
  input  wire logic       parity_type,
  input  wire logic       receiver_wakeup,
  input  wire logic       txe_irq_enable,
  input  wire logic       done_irq_enable,
  input  wire logic       rx_irq_enable,
  input  wire logic       quiet_irq_enable
);

  // ----------------------------------------------------------------
  // Flag storage and clearing sequence
  // ----------------------------------------------------------------
  logic [7:0] flags_q;
  logic [1:0] tx_flags_q;
  logic [5:0] rx_flags_q;
  logic [7:0] arm_q;
  logic [8:0] rx_hold_q;
  logic [3:0] ones_q;
  logic       idle_allow_q;
  logic       stat_rd;
  logic       low_rd;
  logic       low_wr;
  logic       rx_load;
  logic       ovr_evt;
  logic       idle_hit;
  logic [3:0] ones_need;

  function automatic logic parity_bad(input logic [8:0] d, input logic nine, input logic p, input logic odd);
    parity_bad = ((^d[7:0]) ^ (nine & d[8]) ^ p) != odd;
  endfunction : parity_bad

  assign stat_rd = bus.rd && (bus.addr == `UF_OFF_STAT);
  assign low_rd  = bus.rd && (bus.addr == `UF_OFF_DATA_LOW);
  assign low_wr  = bus.wr && (bus.addr == `UF_OFF_DATA_LOW);
  assign flags_q = {tx_flags_q, rx_flags_q};

  // A frame is refused while a framing error stands; a frame that finds the old one unread is lost.
  assign rx_load = rx_done && !flags_q[`UF_BIT_FULL] && !flags_q[`UF_BIT_FRM];
  assign ovr_evt = rx_done && flags_q[`UF_BIT_FULL] && !flags_q[`UF_BIT_FRM];
  assign rx_inhibit = flags_q[`UF_BIT_FRM];

  // Only flags seen set by a status read may be cleared by the following data access.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_q <= 8'h00;
    end else if (stat_rd) begin
      arm_q <= flags_q;
    end else if (low_wr) begin
      arm_q[7:6] <= 2'h0;
    end else if (low_rd) begin
      arm_q[5:0] <= 6'h00;
    end
  end

  // Transmit flags.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_flags_q <= 2'(`UF_STAT_RST >> 6);
    end else begin
      // Set wins over clear for the empty flag.
      if (tx_shift_load)
        tx_flags_q[`UF_BIT_TXE - 6] <= 1'b1;
      else if (low_wr && arm_q[`UF_BIT_TXE])
        tx_flags_q[`UF_BIT_TXE - 6] <= 1'b0;
      // Clear wins over set for the done flag.
      if ((low_wr && arm_q[`UF_BIT_DONE]) || tx_queue || tx_active)
        tx_flags_q[`UF_BIT_DONE - 6] <= 1'b0;
      else if (flags_q[`UF_BIT_TXE])
        tx_flags_q[`UF_BIT_DONE - 6] <= 1'b1;
    end
  end

  assign tx_line_idle = flags_q[`UF_BIT_DONE];

  // Receive flags; an event arriving with its clear keeps the flag set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_flags_q <= 6'(`UF_STAT_RST);
    end else begin
      if (rx_load)
        rx_flags_q[`UF_BIT_FULL] <= 1'b1;
      else if (low_rd && arm_q[`UF_BIT_FULL])
        rx_flags_q[`UF_BIT_FULL] <= 1'b0;
      if (idle_hit)
        rx_flags_q[`UF_BIT_IDLE] <= 1'b1;
      else if (low_rd && arm_q[`UF_BIT_IDLE])
        rx_flags_q[`UF_BIT_IDLE] <= 1'b0;
      if (ovr_evt)
        rx_flags_q[`UF_BIT_OVR] <= 1'b1;
      else if (low_rd && arm_q[`UF_BIT_OVR])
        rx_flags_q[`UF_BIT_OVR] <= 1'b0;
      if (rx_load && rx_noise)
        rx_flags_q[`UF_BIT_NOISE] <= 1'b1;
      else if (low_rd && arm_q[`UF_BIT_NOISE])
        rx_flags_q[`UF_BIT_NOISE] <= 1'b0;
      if (rx_load && !rx_stop_bit)
        rx_flags_q[`UF_BIT_FRM] <= 1'b1;
      else if (low_rd && arm_q[`UF_BIT_FRM])
        rx_flags_q[`UF_BIT_FRM] <= 1'b0;
      if (rx_load && parity_enable && parity_bad(rx_data, nine_bit, rx_parity_bit, parity_type))
        rx_flags_q[`UF_BIT_PAR] <= 1'b1;
      else if (low_rd && arm_q[`UF_BIT_PAR])
        rx_flags_q[`UF_BIT_PAR] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Receive data holding register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rx_hold_q <= 9'h000;
    else if (rx_load)
      rx_hold_q <= rx_data;
  end

  // ----------------------------------------------------------------
  // Idle line detection
  // ----------------------------------------------------------------
  assign ones_need = nine_bit ? `UF_IDLE_ONES9 : `UF_IDLE_ONES8;
  assign idle_hit  = bit_tick && rxd_level && (ones_q == ones_need - 4'h1)
                     && idle_allow_q && !receiver_wakeup;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ones_q <= 4'h0;
    else if (bit_tick && !rxd_level)
      ones_q <= 4'h0;
    else if (bit_tick && ones_q != ones_need)
      ones_q <= ones_q + 4'h1;
  end

  // The line must carry a fresh frame before the idle flag may set once more.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      idle_allow_q <= 1'b1;
    else if (rx_load)
      idle_allow_q <= 1'b1;
    else if (idle_hit)
      idle_allow_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data <= 9'h000;
    end else if (low_wr) begin
      tx_data[7:0] <= bus.wdata;
    end else if (bus.wr && bus.addr == `UF_OFF_DATA_HIGH) begin
      tx_data[8] <= bus.wdata[`UF_BIT_T8];
    end
  end

  // Status writes fall through every decode above and change nothing.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.rdata  <= 8'h00;
      bus.rvalid <= 1'b0;
    end else begin
      bus.rvalid <= bus.rd;
      if (bus.rd) begin
        unique case (bus.addr)
          `UF_OFF_STAT:      bus.rdata <= flags_q;
          `UF_OFF_DATA_LOW:  bus.rdata <= rx_hold_q[7:0];
          `UF_OFF_DATA_HIGH: bus.rdata <= {rx_hold_q[8], tx_data[8], 6'h00};
          default:           bus.rdata <= 8'h00;
        endcase
      end
    end
  end

  assign bus.irq = (txe_irq_enable && flags_q[`UF_BIT_TXE])
                 || (done_irq_enable && flags_q[`UF_BIT_DONE])
                 || (rx_irq_enable && (flags_q[`UF_BIT_FULL] || flags_q[`UF_BIT_OVR]))
                 || (quiet_irq_enable && flags_q[`UF_BIT_IDLE]);

endmodule : uart_flags_dev

// File: include/uart_flags_defines.svh
// Offsets, field positions, reset values and counts of the serial status flag block.
`ifndef UART_FLAGS_DEFINES_SVH
`define UART_FLAGS_DEFINES_SVH
`define UF_OFF_STAT      3'h4
`define UF_OFF_DATA_HIGH 3'h6
`define UF_OFF_DATA_LOW  3'h7
`define UF_BIT_TXE       7
`define UF_BIT_DONE      6
`define UF_BIT_FULL      5
`define UF_BIT_IDLE      4
`define UF_BIT_OVR       3
`define UF_BIT_NOISE     2
`define UF_BIT_FRM       1
`define UF_BIT_PAR       0
`define UF_BIT_R8        7
`define UF_BIT_T8        6
`define UF_STAT_RST      8'hc0
`define UF_IDLE_ONES8    4'ha
`define UF_IDLE_ONES9    4'hb
`define UF_APB_CMD       8'h00
`define UF_APB_STATUS    8'h04
`define UF_APB_RESULT    8'h08
`define UF_APB_IRQ       8'h0c
`define UF_OP_STAT_RD    3'h1
`define UF_OP_LOW_RD     3'h2
`define UF_OP_LOW_WR     3'h3
`define UF_OP_HIGH_RD    3'h4
`define UF_OP_HIGH_WR    3'h5
`define UF_OP_SERVICE    3'h6
`endif

// File: include/uart_flags_pkg.sv
// Types used by the host controller of the serial status flag block.
package uart_flags_pkg;
  typedef enum logic [1:0] {
    H_IDLE,
    H_REQ,
    H_WAIT
  } host_state_t;
endpackage : uart_flags_pkg

// File: include/uart_flags_if.sv
// Register access port between the flag block and its host controller.
`timescale 1ns/10ps
interface uart_flags_if;
  logic [2:0] addr;
  logic       rd;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       irq;
  modport dev  (input addr, rd, wr, wdata, output rdata, rvalid, irq);
  modport host (output addr, rd, wr, wdata, input rdata, rvalid, irq);
endinterface : uart_flags_if

// File: core/uart_flags_host.sv
// Host controller that drives the flag block's register port on orders given over APB.
`timescale 1ns/10ps
`include "uart_flags_defines.svh"

module uart_flags_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Register port
  uart_flags_if.host       bus
);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  uart_flags_pkg::host_state_t state_q;
  logic [2:0] addr_q;
  logic       wr_q;
  logic [7:0] wdata_q;
  logic       svc_q;
  logic [1:0] step_q;
  logic       extra_q;
  logic [7:0] res_stat_q;
  logic [7:0] res_low_q;
  logic [7:0] res_high_q;
  logic       cmd_go;
  logic       svc_more;

  // Service steps alternate status reads and low data reads, so status always comes first.
  function automatic logic [2:0] step_addr(input logic [1:0] s);
    step_addr = s[0] ? `UF_OFF_DATA_LOW : `UF_OFF_STAT;
  endfunction : step_addr

  assign cmd_go = psel && penable && pwrite && (paddr == `UF_APB_CMD)
                  && (state_q == uart_flags_pkg::H_IDLE);
  // An overrun still seen after the data read needs one dummy low read to clear it.
  assign svc_more = svc_q && (step_q != 2'h3)
                    && ((step_q != 2'h2) || bus.rdata[`UF_BIT_OVR]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= uart_flags_pkg::H_IDLE;
      addr_q  <= 3'h0;
      wr_q    <= 1'b0;
      wdata_q <= 8'h00;
      svc_q   <= 1'b0;
      step_q  <= 2'h0;
      extra_q <= 1'b0;
    end else begin
      unique case (state_q)
        uart_flags_pkg::H_IDLE: begin
          if (cmd_go && pwdata[2:0] != 3'h0) begin
            state_q <= uart_flags_pkg::H_REQ;
            wdata_q <= pwdata[15:8];
            svc_q   <= pwdata[2:0] == `UF_OP_SERVICE;
            step_q  <= 2'h0;
            extra_q <= 1'b0;
            wr_q    <= pwdata[2:0] == `UF_OP_LOW_WR || pwdata[2:0] == `UF_OP_HIGH_WR;
            unique case (pwdata[2:0])
              `UF_OP_LOW_RD, `UF_OP_LOW_WR:   addr_q <= `UF_OFF_DATA_LOW;
              `UF_OP_HIGH_RD, `UF_OP_HIGH_WR: addr_q <= `UF_OFF_DATA_HIGH;
              default:                        addr_q <= `UF_OFF_STAT;
            endcase
          end
        end
        uart_flags_pkg::H_REQ: begin
          state_q <= wr_q ? uart_flags_pkg::H_IDLE : uart_flags_pkg::H_WAIT;
        end
        uart_flags_pkg::H_WAIT: begin
          if (bus.rvalid) begin
            if (svc_more) begin
              state_q <= uart_flags_pkg::H_REQ;
              step_q  <= step_q + 2'h1;
              addr_q  <= step_addr(step_q + 2'h1);
              extra_q <= step_q == 2'h2;
            end else begin
              state_q <= uart_flags_pkg::H_IDLE;
            end
          end
        end
        default: state_q <= uart_flags_pkg::H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_stat_q <= 8'h00;
      res_low_q  <= 8'h00;
      res_high_q <= 8'h00;
    end else if (state_q == uart_flags_pkg::H_WAIT && bus.rvalid) begin
      unique case (addr_q)
        `UF_OFF_STAT:     res_stat_q <= bus.rdata;
        `UF_OFF_DATA_LOW: if (!extra_q) res_low_q <= bus.rdata;
        default:          res_high_q <= bus.rdata;
      endcase
    end
  end

  assign bus.addr  = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.rd    = (state_q == uart_flags_pkg::H_REQ) && !wr_q;
  assign bus.wr    = (state_q == uart_flags_pkg::H_REQ) && wr_q;

  // ----------------------------------------------------------------
  // APB read data, captured in the setup cycle
  // ----------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (paddr)
        `UF_APB_STATUS: prdata <= {30'h0, extra_q, state_q != uart_flags_pkg::H_IDLE};
        `UF_APB_RESULT: prdata <= {8'h00, res_high_q, res_low_q, res_stat_q};
        `UF_APB_IRQ:    prdata <= {31'h0, bus.irq};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : uart_flags_host

// File: test/uart_flags_properties.sv
// Checker for the register port joining the flag block and its host controller.
`timescale 1ns/10ps
`include "uart_flags_defines.svh"
module uart_flags_properties (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [2:0] addr,
  input wire logic       rd,
  input wire logic       wr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       irq
);
  // Last status seen, and which data accesses came after it.
  logic       stat_q;
  logic       seen_q;
  logic [7:0] prev_q;
  logic       lrd_q;
  logic       lwr_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= 1'b0;
      seen_q <= 1'b0;
      prev_q <= 8'h00;
    end else begin
      stat_q <= rd && addr == `UF_OFF_STAT;
      if (rvalid && stat_q) begin
        seen_q <= 1'b1;
        prev_q <= rdata;
      end
    end
  end
  // An access in the same cycle as the status answer counts for the next read.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lrd_q <= 1'b0;
      lwr_q <= 1'b0;
    end else begin
      lrd_q <= (rd && addr == `UF_OFF_DATA_LOW) || (lrd_q && !(rvalid && stat_q));
      lwr_q <= (wr && addr == `UF_OFF_DATA_LOW) || (lwr_q && !(rvalid && stat_q));
    end
  end
  chk_read_answer: assert property (rd |=> rvalid)
    else $error("read got no answer in the next cycle");
  chk_no_stray: assert property (!rd |=> !rvalid)
    else $error("answer without a read");
  chk_rdata_hold: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without a read");
  chk_strobe_excl: assert property (!(rd && wr))
    else $error("read and write strobes together");
  chk_addr_legal: assert property ((rd || wr) |-> addr inside {3'h4, 3'h6, 3'h7})
    else $error("access to an unused offset");
  chk_txe_sticky: assert property (rvalid && stat_q && seen_q && prev_q[7] && !lwr_q |-> rdata[7])
    else $error("tx empty cleared without a low write");
  chk_rx_sticky: assert property (rvalid && stat_q && seen_q && !lrd_q |-> (rdata[5:0] & prev_q[5:0]) == prev_q[5:0])
    else $error("receive flag cleared without a low read");
  chk_err_full: assert property (rvalid && stat_q && (|rdata[2:0]) |-> rdata[5])
    else $error("error flag without rx full");
endmodule : uart_flags_properties

// File: test/uart_status_flags_bench.sv
// Self-checking bench joining both ends of the serial status flag block.
`timescale 1ns/10ps
module uart_status_flags_bench;
  logic        clk, rst_n, psel, penable, pwrite, pready;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, res;
  logic        ld, act, q, rxd, nz, stp, par, tk, lvl, nb, pen, pt, wu, qe, te, de, re, inh, idl;
  logic [8:0]  rdat, txd;
  int          error_cnt, num_checks;
  uart_flags_if uart_flags_if_i ();
  uart_flags_dev uart_flags_dev_i (.clk(clk), .rst_n(rst_n), .bus(uart_flags_if_i), .tx_shift_load(ld),
    .tx_active(act), .tx_queue(q), .tx_data(txd), .tx_line_idle(idl), .rx_done(rxd), .rx_data(rdat),
    .rx_noise(nz), .rx_stop_bit(stp), .rx_parity_bit(par), .bit_tick(tk), .rxd_level(lvl), .rx_inhibit(inh),
    .nine_bit(nb), .parity_enable(pen), .parity_type(pt), .receiver_wakeup(wu), .txe_irq_enable(te),
    .done_irq_enable(de), .rx_irq_enable(re), .quiet_irq_enable(qe));
  uart_flags_host uart_flags_host_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
    .bus(uart_flags_if_i));
  uart_flags_properties uart_flags_properties_i (.clk(clk), .rst_n(rst_n), .addr(uart_flags_if_i.addr),
    .rd(uart_flags_if_i.rd), .wr(uart_flags_if_i.wr), .wdata(uart_flags_if_i.wdata),
    .rdata(uart_flags_if_i.rdata), .rvalid(uart_flags_if_i.rvalid), .irq(uart_flags_if_i.irq));
  always #2 clk = ~clk;
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic results;
    $display("mismatches %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic guard(input logic bad);
    if (bad) begin
      error_cnt++;
      $display("unexpected at %0t: wait ran out", $time);
      results();
    end
  endtask : guard
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    guard(pready !== 1'b1);
    res = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Polls the host until it is idle, then fetches the result word.
  task automatic finish_op;
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end while (res[0] !== 1'b0 && n < 50);
    guard(res[0] !== 1'b0);
    apb(1'b0, 8'h08, 32'h0);
  endtask : finish_op
  // Orders one access and waits until the host is no longer busy.
  task automatic op(input logic [2:0] c, input logic [7:0] b);
    apb(1'b1, 8'h00, {16'h0, b, 5'h0, c});
    finish_op();
  endtask : op
  task automatic st(input logic [7:0] e);
    op(3'h1, 8'h00);
    check(res[7:0], e);
  endtask : st
  task automatic lo(input logic [7:0] e);
    op(3'h2, 8'h00);
    check(res[15:8], e);
  endtask : lo
  task automatic irq_is(input logic [7:0] e);
    apb(1'b0, 8'h0c, 32'h0);
    check(res[7:0], e);
  endtask : irq_is
  task automatic load;
    @(posedge clk) ld <= 1'b1;
    @(posedge clk) ld <= 1'b0;
  endtask : load
  task automatic frame(input logic [7:0] d, input logic n, input logic s, input logic p);
    @(posedge clk);
    rdat <= {1'b0, d};
    nz <= n;
    stp <= s;
    par <= p;
    rxd <= 1'b1;
    @(posedge clk) rxd <= 1'b0;
  endtask : frame
  task automatic ticks(input int n, input logic l);
    repeat (n) begin
      @(posedge clk);
      tk <= 1'b1;
      lvl <= l;
      @(posedge clk) tk <= 1'b0;
    end
  endtask : ticks
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {clk, rst_n, psel, penable, pwrite, ld, act, q, rxd, nz, stp, par, tk, lvl, nb, pen, pt, wu, te, de, re} = '0;
    {paddr, pwdata, rdat} = '0;
    qe = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    st(8'hc0);
    check({7'h0, idl}, 8'h01);
    irq_is(8'h00);
    te <= 1'b1;
    irq_is(8'h01);
    te <= 1'b0;
    de <= 1'b1;
    irq_is(8'h01);
    de <= 1'b0;
    op(3'h3, 8'h3c);
    check(txd[7:0], 8'h3c);
    st(8'h00);
    @(posedge clk) act <= 1'b1;
    load();
    st(8'h80);
    check({7'h0, idl}, 8'h00);
    @(posedge clk) act <= 1'b0;
    st(8'hc0);
    @(posedge clk) q <= 1'b1;
    act <= 1'b1;
    @(posedge clk) q <= 1'b0;
    st(8'h80);
    @(posedge clk) act <= 1'b0;
    op(3'h3, 8'h55);
    load();
    op(3'h3, 8'h66);
    st(8'hc0);
    frame(8'h5a, 1'b0, 1'b1, 1'b0);
    st(8'he0);
    lo(8'h5a);
    st(8'hc0);
    frame(8'h11, 1'b0, 1'b1, 1'b0);
    st(8'he0);
    frame(8'h22, 1'b1, 1'b1, 1'b0);
    lo(8'h11);
    st(8'hc8);
    re <= 1'b1;
    irq_is(8'h01);
    re <= 1'b0;
    lo(8'h11);
    st(8'hc0);
    pen <= 1'b1;
    frame(8'h01, 1'b1, 1'b0, 1'b0);
    st(8'he7);
    check({7'h0, inh}, 8'h01);
    frame(8'h33, 1'b0, 1'b1, 1'b1);
    st(8'he7);
    lo(8'h01);
    st(8'hc0);
    pen <= 1'b0;
    ticks(1, 1'b0);
    ticks(9, 1'b1);
    st(8'hc0);
    ticks(1, 1'b1);
    st(8'hd0);
    irq_is(8'h01);
    lo(8'h01);
    st(8'hc0);
    irq_is(8'h00);
    ticks(1, 1'b0);
    ticks(12, 1'b1);
    st(8'hc0);
    frame(8'h44, 1'b0, 1'b1, 1'b0);
    lo(8'h44);
    wu <= 1'b1;
    ticks(1, 1'b0);
    ticks(12, 1'b1);
    st(8'he0);
    wu <= 1'b0;
    nb <= 1'b1;
    ticks(1, 1'b0);
    ticks(10, 1'b1);
    lo(8'h44);
    st(8'hc0);
    ticks(1, 1'b1);
    st(8'hd0);
    // An overrun landing between the service's status read and its data read needs the dummy read.
    frame(8'h77, 1'b0, 1'b1, 1'b0);
    apb(1'b1, 8'h00, {29'h0, 3'h6});
    frame(8'h88, 1'b0, 1'b1, 1'b0);
    finish_op();
    check(res[7:0], 8'hc8);
    check(res[15:8], 8'h77);
    apb(1'b0, 8'h04, 32'h0);
    check(res[7:0], 8'h02);
    st(8'hc0);
    pen <= 1'b1;
    pt <= 1'b1;
    frame(8'h99, 1'b0, 1'b1, 1'b1);
    st(8'he0);
    op(3'h5, 8'h40);
    check({7'h0, txd[8]}, 8'h01);
    op(3'h4, 8'h00);
    check(res[23:16], 8'h40);
    lo(8'h99);
    st(8'hc0);
    apb(1'b0, 8'h10, 32'h0);
    check(res[7:0], 8'h00);
    results();
  end
endmodule : uart_status_flags_bench
